/* include/rmap_svc_pkg.sv */
// Purpose: shared constants and types for the rmap subnetwork service ends
// Assumes: one word per rmap access, word address space of ADDR_W bits
// Notes: address bits [7:6] select the service region
package rmap_svc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int TID_W = 16;
	// ---------------------------------------------------------------
	// service regions, one per communication service
	// ---------------------------------------------------------------
	localparam logic [1:0] REG_CMD_PKT = 2'h0;
	localparam logic [1:0] REG_TLM_PKT = 2'h1;
	localparam logic [1:0] REG_MEM_RAW = 2'h2;
	localparam logic [1:0] REG_TIME = 2'h3;
	localparam logic [7:0] CMD_PKT_BASE = 8'h00;
	localparam logic [7:0] TLM_PKT_BASE = 8'h40;
	localparam logic [7:0] TLM_ACK_ADDR = 8'h7E;
	localparam logic [7:0] TLM_PEND_ADDR = 8'h7F;
	localparam logic [7:0] MEM_RAW_BASE = 8'h80;
	localparam logic [7:0] TIME_BASE = 8'hC0;
	// arbitrary access key value
	localparam logic [7:0] ACCESS_KEY = 8'h5A;
	localparam logic [7:0] PEND_RESET = 8'h00;
	// ---------------------------------------------------------------
	// reply status codes
	// ---------------------------------------------------------------
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_BAD_KEY = 8'h03;
	localparam logic [7:0] ST_BAD_ADDR = 8'h0A;
	localparam logic [7:0] ST_TIMEOUT = 8'hFF;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int REPLY_TIMEOUT_NS = 2000;
	localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int POLL_PERIOD_NS = 4000;
	localparam int POLL_PERIOD_CYC = POLL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MAX_RETRIES = 3;
	typedef enum logic [1:0] {
		CLASS_BEST_EFFORT = 2'b00,
		CLASS_ASSURED = 2'b01,
		CLASS_RESERVED = 2'b10,
		CLASS_GUARANTEED = 2'b11
	} traffic_class_t;
endpackage

/* include/rmap_link_if.sv */
// Purpose: command and reply channels between rmap initiator and target
// Assumes: one clock; the testbench joins both ends through this
// Notes: cmd_eep marks a command truncated by an error end of packet
`timescale 1ns/1ps
interface rmap_link_if;
	import rmap_svc_pkg::*;
	logic cmd_valid;
	logic cmd_ready;
	logic cmd_write;
	logic cmd_eep;
	logic [TID_W-1:0] cmd_tid;
	logic [7:0] cmd_key;
	logic [ADDR_W-1:0] cmd_addr;
	logic [DATA_W-1:0] cmd_data;
	logic rep_valid;
	logic rep_write;
	logic [TID_W-1:0] rep_tid;
	logic [7:0] rep_status;
	logic [DATA_W-1:0] rep_data;
	modport initiator (
		output cmd_valid, cmd_write, cmd_eep, cmd_tid, cmd_key, cmd_addr, cmd_data,
		input cmd_ready, rep_valid, rep_write, rep_tid, rep_status, rep_data
	);
	modport target (
		input cmd_valid, cmd_write, cmd_eep, cmd_tid, cmd_key, cmd_addr, cmd_data,
		output cmd_ready, rep_valid, rep_write, rep_tid, rep_status, rep_data
	);
endinterface // rmap_link_if

/* verilog/rmap_user_target.sv */
// Purpose: user device end, always the rmap target
// Assumes: one command in flight; a reply follows each valid command not marked cmd_eep
// Notes: regions split by address bits [7:6]
`timescale 1ns/1ps
module rmap_user_target #(
	parameter int PEND_W = 8
) (
	input wire logic clock,
	input wire logic reset,
	rmap_link_if.target link,
	input wire logic tlm_wr,
	input wire logic [5:0] tlm_index,
	input wire logic [rmap_svc_pkg::DATA_W-1:0] tlm_data,
	input wire logic tlm_push,
	output logic [PEND_W-1:0] tlm_pending,
	output logic cmd_pkt_strobe,
	output logic [rmap_svc_pkg::DATA_W-1:0] cmd_pkt_data,
	output logic time_strobe,
	output logic [rmap_svc_pkg::DATA_W-1:0] time_value
);
	import rmap_svc_pkg::*;

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [PEND_W-1:0] pend_reg;
	logic take;
	logic key_ok;
	logic addr_ok;
	logic exec;
	logic [1:0] region;
	logic ack_hit;

	// ---------------------------------------------------------------
	// command checks
	// ---------------------------------------------------------------
	assign link.cmd_ready = !link.rep_valid;
	// truncated commands are dropped whole, no write and no reply
	assign take = link.cmd_valid && link.cmd_ready && !link.cmd_eep;
	assign region = link.cmd_addr[7:6];
	assign key_ok = link.cmd_key == ACCESS_KEY;
	// telemetry region is read-only to the master except the ack word
	always_comb begin
		addr_ok = 1'b1;
		if (link.cmd_write && region == REG_TLM_PKT && link.cmd_addr != TLM_ACK_ADDR) begin
			addr_ok = 1'b0;
		end
	end
	// transaction id never gates execution; repeats execute again
	assign exec = take && key_ok && addr_ok;
	assign ack_hit = exec && link.cmd_write && link.cmd_addr == TLM_ACK_ADDR;

	// ---------------------------------------------------------------
	// service memory
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (exec && link.cmd_write && region != REG_TLM_PKT) begin
			mem[link.cmd_addr] <= link.cmd_data;
		end
		// regions never overlap, so a user write must not lose to a master write
		if (tlm_wr) begin
			mem[{REG_TLM_PKT, tlm_index}] <= tlm_data;
		end
	end

	// ---------------------------------------------------------------
	// pending output packet count, polled by the master
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			pend_reg <= PEND_RESET[PEND_W-1:0];
		end else if (tlm_push && !ack_hit) begin
			if (pend_reg != '1) begin
				pend_reg <= pend_reg + 1'b1;
			end
		end else if (ack_hit && !tlm_push && pend_reg != '0) begin
			pend_reg <= pend_reg - 1'b1;
		end
	end
	assign tlm_pending = pend_reg;

	// ---------------------------------------------------------------
	// reply; no confirmation or retry logic on this side
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			link.rep_valid <= 1'b0;
			link.rep_write <= 1'b0;
			link.rep_tid <= '0;
			link.rep_status <= ST_OK;
			link.rep_data <= '0;
		end else begin
			link.rep_valid <= take;
			if (take) begin
				link.rep_write <= link.cmd_write;
				link.rep_tid <= link.cmd_tid;
				link.rep_status <= !key_ok ? ST_BAD_KEY : (!addr_ok ? ST_BAD_ADDR : ST_OK);
				if (link.cmd_addr == TLM_PEND_ADDR) begin
					link.rep_data <= DATA_W'(pend_reg);
				end else begin
					link.rep_data <= mem[link.cmd_addr];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// user side deliveries
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			cmd_pkt_strobe <= 1'b0;
			cmd_pkt_data <= '0;
			time_strobe <= 1'b0;
			time_value <= '0;
		end else begin
			cmd_pkt_strobe <= exec && link.cmd_write && region == REG_CMD_PKT;
			time_strobe <= exec && link.cmd_write && region == REG_TIME;
			if (exec && link.cmd_write && region == REG_CMD_PKT) begin
				cmd_pkt_data <= link.cmd_data;
			end
			if (exec && link.cmd_write && region == REG_TIME) begin
				time_value <= link.cmd_data;
			end
		end
	end
endmodule // rmap_user_target

/* verilog/rmap_master_initiator.sv */
// Purpose: master device end, always the rmap initiator
// Assumes: one transaction outstanding at a time
// Notes: polls the user pending count, fetches and acknowledges packets
//
// How it works
// - master initiates, user device only answers
// - master learns requests only by polling
// - each service owns its own address region
// - master reads or writes when it chooses
// - pending count polled, then fixed fetch access
// - class from time-division and retransmission choice
// - packets, raw data and time regions separate
// - raw memory access without retries; the target still replies to each one
// - time master writes time into user
// - error-ended commands never execute
// - retries reuse the failed transaction id
// - retransmission chosen per communication type
// - missing reply within timeout means failure
// - target executes regardless of transaction id
`timescale 1ns/1ps
module rmap_master_initiator #(
	parameter int TIMEOUT_CYC = rmap_svc_pkg::REPLY_TIMEOUT_CYC,
	parameter int POLL_CYC = rmap_svc_pkg::POLL_PERIOD_CYC,
	parameter int RETRY_MAX = rmap_svc_pkg::MAX_RETRIES
) (
	input wire logic clock,
	input wire logic reset,
	rmap_link_if.initiator link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_reliable,
	input wire logic [rmap_svc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [rmap_svc_pkg::DATA_W-1:0] req_data,
	input wire logic poll_enable,
	input wire logic tlm_reliable,
	input wire logic tdm_enable,
	output logic done,
	output logic fail,
	output logic [7:0] rsp_status,
	output logic [rmap_svc_pkg::DATA_W-1:0] rsp_data,
	output logic pkt_valid,
	output logic [rmap_svc_pkg::DATA_W-1:0] pkt_data,
	output rmap_svc_pkg::traffic_class_t traffic_class
);
	import rmap_svc_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b10
	} state_t;

	// which job the outstanding transaction belongs to
	typedef enum logic [1:0] {
		JOB_USER = 2'b00,
		JOB_POLL = 2'b01,
		JOB_FETCH = 2'b10,
		JOB_ACK = 2'b11
	} job_t;

	state_t state_reg;
	job_t job_reg;
	logic write_reg;
	logic reliable_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [TID_W-1:0] tid_reg;
	logic [TID_W-1:0] tid_next;
	logic [$clog2(TIMEOUT_CYC+1)-1:0] wait_cnt;
	logic [$clog2(POLL_CYC+1)-1:0] poll_cnt;
	logic [$clog2(RETRY_MAX+1)-1:0] retry_cnt;
	logic poll_due;
	logic reply_hit;
	logic timed_out;
	logic fetch_go;
	logic ack_go;

	assign tid_next = tid_reg + 1'b1;
	assign reply_hit = state_reg == ST_WAIT && link.rep_valid && link.rep_tid == tid_reg;
	assign timed_out = state_reg == ST_WAIT && !reply_hit && wait_cnt == TIMEOUT_CYC[$bits(wait_cnt)-1:0];
	assign fetch_go = reply_hit && job_reg == JOB_POLL && link.rep_status == ST_OK && link.rep_data != '0;
	assign ack_go = reply_hit && job_reg == JOB_FETCH && link.rep_status == ST_OK;
	// user requests only taken while idle and no poll is owed
	assign req_ready = state_reg == ST_IDLE && !poll_due;

	// ---------------------------------------------------------------
	// traffic class from the two design choices
	// ---------------------------------------------------------------
	always_comb begin
		unique case ({tdm_enable, req_reliable})
			2'b00: traffic_class = CLASS_BEST_EFFORT;
			2'b01: traffic_class = CLASS_ASSURED;
			2'b10: traffic_class = CLASS_RESERVED;
			2'b11: traffic_class = CLASS_GUARANTEED;
		endcase
	end

	// ---------------------------------------------------------------
	// command channel, master is the only originator
	// ---------------------------------------------------------------
	assign link.cmd_valid = state_reg == ST_SEND;
	assign link.cmd_write = write_reg;
	assign link.cmd_eep = 1'b0;
	assign link.cmd_tid = tid_reg;
	assign link.cmd_key = ACCESS_KEY;
	assign link.cmd_addr = addr_reg;
	assign link.cmd_data = data_reg;

	// ---------------------------------------------------------------
	// poll timer; the user cannot push, so it is asked periodically
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			poll_cnt <= '0;
			poll_due <= 1'b0;
		end else if (!poll_enable) begin
			poll_cnt <= '0;
			poll_due <= 1'b0;
		end else if (state_reg == ST_IDLE && poll_due) begin
			poll_due <= 1'b0;
		end else if (poll_cnt == POLL_CYC[$bits(poll_cnt)-1:0]) begin
			poll_cnt <= '0;
			poll_due <= 1'b1;
		end else begin
			poll_cnt <= poll_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// transaction sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			job_reg <= JOB_USER;
			write_reg <= 1'b0;
			reliable_reg <= 1'b0;
			addr_reg <= '0;
			data_reg <= '0;
			tid_reg <= '0;
			retry_cnt <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					retry_cnt <= '0;
					if (poll_due) begin
						// fixed access to the pending count
						state_reg <= ST_SEND;
						job_reg <= JOB_POLL;
						write_reg <= 1'b0;
						reliable_reg <= 1'b0;
						addr_reg <= TLM_PEND_ADDR;
						tid_reg <= tid_next;
					end else if (req_valid) begin
						state_reg <= ST_SEND;
						job_reg <= JOB_USER;
						write_reg <= req_write;
						// raw memory region never retried here
						reliable_reg <= req_reliable && req_addr[7:6] != REG_MEM_RAW;
						addr_reg <= req_addr;
						data_reg <= req_data;
						tid_reg <= tid_next;
					end
				end
				ST_SEND: begin
					if (link.cmd_ready) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (fetch_go) begin
						state_reg <= ST_SEND;
						job_reg <= JOB_FETCH;
						write_reg <= 1'b0;
						reliable_reg <= tlm_reliable;
						addr_reg <= TLM_PKT_BASE;
						tid_reg <= tid_next;
						retry_cnt <= '0;
					end else if (ack_go) begin
						state_reg <= ST_SEND;
						job_reg <= JOB_ACK;
						write_reg <= 1'b1;
						addr_reg <= TLM_ACK_ADDR;
						data_reg <= '0;
						tid_reg <= tid_next;
						retry_cnt <= '0;
					end else if (reply_hit) begin
						state_reg <= ST_IDLE;
					end else if (timed_out) begin
						if (reliable_reg && retry_cnt < RETRY_MAX[$bits(retry_cnt)-1:0]) begin
							// same id on the resend
							state_reg <= ST_SEND;
							retry_cnt <= retry_cnt + 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wait_cnt <= '0;
		end else if (state_reg == ST_WAIT && !reply_hit && !timed_out) begin
			wait_cnt <= wait_cnt + 1'b1;
		end else begin
			wait_cnt <= '0;
		end
	end

	// ---------------------------------------------------------------
	// results toward the upper layer
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			done <= 1'b0;
			fail <= 1'b0;
			rsp_status <= ST_OK;
			rsp_data <= '0;
			pkt_valid <= 1'b0;
			pkt_data <= '0;
		end else begin
			done <= reply_hit && job_reg == JOB_USER;
			fail <= timed_out && !(reliable_reg && retry_cnt < RETRY_MAX[$bits(retry_cnt)-1:0]);
			pkt_valid <= ack_go;
			if (reply_hit && job_reg == JOB_USER) begin
				rsp_status <= link.rep_status;
				rsp_data <= link.rep_data;
			end else if (timed_out) begin
				rsp_status <= ST_TIMEOUT;
			end
			if (ack_go) begin
				pkt_data <= link.rep_data;
			end
		end
	end
endmodule // rmap_master_initiator

/* dv/rmap_link_sva.sv */
// Purpose: link checks between the joined initiator and target
// Assumes: one clock; watches the first link only
// Notes: reply fields hold between replies
`timescale 1ns/1ps
module rmap_link_sva (
	input wire logic clock,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_write,
	input wire logic cmd_eep,
	input wire logic [rmap_svc_pkg::TID_W-1:0] cmd_tid,
	input wire logic [rmap_svc_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic rep_valid,
	input wire logic rep_write,
	input wire logic [rmap_svc_pkg::TID_W-1:0] rep_tid,
	input wire logic [7:0] rep_status
);
	import rmap_svc_pkg::*;
	logic [TID_W-1:0] last_tid_reg;
	logic seen_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	sequence s_take;
		cmd_valid && cmd_ready && !cmd_eep;
	endsequence
	sequence s_tlm_wr;
		cmd_write && cmd_addr >= TLM_PKT_BASE && cmd_addr < TLM_ACK_ADDR;
	endsequence
	// tid 0 is never used after reset, so it stands in for none seen
	always_ff @(posedge clock) begin
		if (reset)
			seen_reg <= 1'b0;
		else if (cmd_valid && cmd_ready)
			seen_reg <= 1'b1;
	end
	always_ff @(posedge clock) begin
		if (cmd_valid && cmd_ready)
			last_tid_reg <= cmd_tid;
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_reply_next_cycle: assert property (s_take |=> rep_valid && rep_tid == $past(cmd_tid)
		&& rep_write == $past(cmd_write)) else $error("reply late or tid not echoed");
	a_no_orphan_reply: assert property (!(cmd_valid && cmd_ready) |=> !rep_valid)
		else $error("reply without a command");
	a_busy_in_reply: assert property (rep_valid |-> !cmd_ready ##1 !rep_valid)
		else $error("reply not a single cycle or ready during reply");
	a_master_no_eep: assert property (cmd_valid |-> !cmd_eep)
		else $error("initiator offered an error-ended command");
	a_tlm_write_refused: assert property (s_take ##0 s_tlm_wr |=> rep_status == ST_BAD_ADDR)
		else $error("telemetry region write not refused");
	a_ok_status: assert property (s_take ##0 !(cmd_write && cmd_addr >= TLM_PKT_BASE
		&& cmd_addr < TLM_ACK_ADDR) |=> rep_status == ST_OK) else $error("valid command not answered ok");
	a_fresh_tid: assert property (s_take |-> cmd_tid != (seen_reg ? last_tid_reg : 16'h0000))
		else $error("new transaction reused the previous tid");
	a_fields_hold: assert property (!rep_valid |-> $stable(rep_tid) && $stable(rep_status))
		else $error("reply fields moved without a reply");
endmodule // rmap_link_sva

/* dv/tb_top.sv */
// Purpose: joins both ends and checks the services through their user sides
// Assumes: short timeout and poll counts for a quick run
// Notes: second link has a silent target, third a bench-driven initiator
`timescale 1ns/1ps
module tb_top;
	import rmap_svc_pkg::*;
	localparam int TMO = 20;
	localparam int POLL = 40;
	localparam int RMAX = 3;
	logic clock = 0, reset = 1, req_valid = 0, req_write = 0, req_reliable = 0, poll_enable = 0;
	logic tlm_reliable = 0, tdm_enable = 0, req2_valid = 0, req2_write = 0, req2_reliable = 0;
	logic tlm_wr = 0, tlm_push = 0, req_ready, done, fail, pkt_valid, req2_ready, done2, fail2;
	logic cmd_pkt_strobe, time_strobe, t2_strobe;
	logic [5:0] tlm_index = 0;
	logic [7:0] req_addr = 0, req2_addr = 0, tlm_pending, rsp_status, rsp2_status;
	logic [31:0] req_data = 0, req2_data = 0, tlm_data = 0, rsp_data, pkt_data, cmd_pkt_data, time_value;
	logic [15:0] tid2;
	traffic_class_t traffic_class;
	traffic_class_t exp_tc[4] = '{CLASS_BEST_EFFORT, CLASS_ASSURED, CLASS_RESERVED, CLASS_GUARANTEED};
	int miscompares = 0, tests_run = 0, cyc = 0, n_cmd = 0, n_time = 0, n2 = 0, n2_diff = 0, n;
	rmap_link_if l1();
	rmap_link_if l2();
	rmap_link_if l3();
	rmap_user_target #(.PEND_W(8)) rmap_user_target_inst (.clock(clock), .reset(reset), .link(l1.target),
		.tlm_wr(tlm_wr), .tlm_index(tlm_index), .tlm_data(tlm_data), .tlm_push(tlm_push),
		.tlm_pending(tlm_pending), .cmd_pkt_strobe(cmd_pkt_strobe), .cmd_pkt_data(cmd_pkt_data),
		.time_strobe(time_strobe), .time_value(time_value));
	rmap_master_initiator #(.TIMEOUT_CYC(TMO), .POLL_CYC(POLL), .RETRY_MAX(RMAX)) rmap_master_initiator_inst (
		.clock(clock), .reset(reset), .link(l1.initiator), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_reliable(req_reliable), .req_addr(req_addr), .req_data(req_data),
		.poll_enable(poll_enable), .tlm_reliable(tlm_reliable), .tdm_enable(tdm_enable), .done(done),
		.fail(fail), .rsp_status(rsp_status), .rsp_data(rsp_data), .pkt_valid(pkt_valid),
		.pkt_data(pkt_data), .traffic_class(traffic_class));
	rmap_master_initiator #(.TIMEOUT_CYC(TMO), .POLL_CYC(POLL), .RETRY_MAX(RMAX)) rmap_master_initiator_inst2 (
		.clock(clock), .reset(reset), .link(l2.initiator), .req_valid(req2_valid), .req_ready(req2_ready),
		.req_write(req2_write), .req_reliable(req2_reliable), .req_addr(req2_addr), .req_data(req2_data),
		.poll_enable(1'b0), .tlm_reliable(tlm_reliable), .tdm_enable(tdm_enable), .done(done2),
		.fail(fail2), .rsp_status(rsp2_status), .rsp_data(), .pkt_valid(), .pkt_data(), .traffic_class());
	rmap_user_target #(.PEND_W(8)) rmap_user_target_inst2 (.clock(clock), .reset(reset), .link(l3.target),
		.tlm_wr(tlm_wr), .tlm_index(tlm_index), .tlm_data(tlm_data), .tlm_push(tlm_push), .tlm_pending(),
		.cmd_pkt_strobe(t2_strobe), .cmd_pkt_data(), .time_strobe(), .time_value());
	rmap_link_sva rmap_link_sva_inst (.clock(clock), .reset(reset), .cmd_valid(l1.cmd_valid),
		.cmd_ready(l1.cmd_ready), .cmd_write(l1.cmd_write), .cmd_eep(l1.cmd_eep), .cmd_tid(l1.cmd_tid),
		.cmd_addr(l1.cmd_addr), .rep_valid(l1.rep_valid), .rep_write(l1.rep_write), .rep_tid(l1.rep_tid),
		.rep_status(l1.rep_status));
	// ---------------------------------------------------------------
	// clock, monitors, tasks
	// ---------------------------------------------------------------
	initial forever #4 clock = ~clock;
	// pulses are counted at the edge so none is missed between checks
	always @(posedge clock) begin
		cyc++;
		if (cmd_pkt_strobe) n_cmd++;
		if (time_strobe) n_time++;
		if (l2.cmd_valid && l2.cmd_ready) begin
			if (n2 > 0 && l2.cmd_tid !== tid2) n2_diff++;
			tid2 = l2.cmd_tid;
			n2++;
		end
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic mreq(input bit b, input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		if (b) {req2_write, req2_reliable, req2_addr, req2_data, req2_valid} = {w, r, a, d, 1'b1};
		else {req_write, req_reliable, req_addr, req_data, req_valid} = {w, r, a, d, 1'b1};
		@(posedge clock);
		while ((b ? req2_ready : req_ready) !== 1'b1 && k < 300) begin
			@(posedge clock);
			k++;
		end
		#1 req_valid = 0;
		req2_valid = 0;
		k = 0;
		while ((b ? (done2 | fail2) : (done | fail)) !== 1'b1 && k < 400) begin
			@(posedge clock);
			#1 k++;
		end
		chk("completion", 1, k < 400);
	endtask
	// bench stands in for the initiator; released data is inverted
	task automatic tcmd(input logic e, input logic [7:0] key, input logic [31:0] d);
		int k;
		k = 0;
		{l3.cmd_write, l3.cmd_eep, l3.cmd_key, l3.cmd_addr, l3.cmd_data} = {1'b1, e, key, 8'h05, d};
		l3.cmd_tid = 16'h0007;
		l3.cmd_valid = 1;
		@(posedge clock);
		while (l3.cmd_ready !== 1'b1 && k < 20) begin
			@(posedge clock);
			k++;
		end
		#1 l3.cmd_valid = 0;
		l3.cmd_data = ~d;
		chk("target reply", !e, l3.rep_valid);
		chk("target strobe", !e && key == ACCESS_KEY, t2_strobe);
		if (!e) chk("target status", key == ACCESS_KEY ? ST_OK : ST_BAD_KEY, l3.rep_status);
		// let an edge pass so the next call never re-raises valid in this time step
		@(posedge clock);
		#1;
	endtask
	task automatic stop_test();
		$display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		{l2.rep_valid, l2.rep_write, l2.rep_tid, l2.rep_status, l2.rep_data} = '0;
		l2.cmd_ready = 1;
		{l3.cmd_valid, l3.cmd_write, l3.cmd_eep, l3.cmd_tid, l3.cmd_key, l3.cmd_addr, l3.cmd_data} = '0;
		repeat (4) @(posedge clock);
		#1 reset = 0;
		for (int i = 0; i < 2; i++) begin
			mreq(0, 1, 1, 8'h05, 32'hA5A5_0001);
			chk("cmd status", ST_OK, rsp_status);
			chk("cmd strobes", i + 1, n_cmd);
			chk("cmd data", 32'hA5A5_0001, cmd_pkt_data);
		end
		mreq(0, 1, 0, 8'hC3, 32'h1234_5678);
		chk("time strobes", 1, n_time);
		chk("time value", 32'h1234_5678, time_value);
		mreq(0, 1, 1, 8'h85, 32'hCAFE_F00D);
		mreq(0, 0, 1, 8'h85, 32'h0000_0000);
		chk("raw read", 32'hCAFE_F00D, rsp_data);
		chk("cmd untouched", 2, n_cmd);
		mreq(0, 1, 0, 8'h45, 32'h0000_0001);
		chk("tlm write", ST_BAD_ADDR, rsp_status);
		$display("test local_access finished");
		for (int i = 0; i < 4; i++) begin
			{tdm_enable, req_reliable} = i[1:0];
			@(posedge clock);
			#1 chk("class", exp_tc[i], traffic_class);
		end
		$display("test traffic_class finished");
		{tlm_index, tlm_data, tlm_wr, tlm_push, tlm_reliable} = {6'h00, 32'h0BAD_BEEF, 3'b111};
		@(posedge clock);
		#1 {tlm_wr, tlm_push} = 2'b00;
		@(posedge clock);
		#1 chk("pending", 1, tlm_pending);
		poll_enable = 1;
		n = 0;
		while (pkt_valid !== 1'b1 && n < 300) begin
			@(posedge clock);
			#1 n++;
		end
		chk("poll fetch", 1, n < 300);
		chk("packet", 32'h0BAD_BEEF, pkt_data);
		repeat (6) @(posedge clock);
		#1 chk("pending acked", 0, tlm_pending);
		poll_enable = 0;
		$display("test user_trigger finished");
		for (int i = 0; i < 3; i++) begin
			n2 = 0;
			n2_diff = 0;
			mreq(1, 1, i != 2, i == 1 ? 8'h85 : 8'h05, 32'h0000_0042);
			chk("attempts", i == 0 ? RMAX + 1 : 1, n2);
			chk("same tid", 0, n2_diff);
			chk("gave up", 1, fail2);
			chk("timeout status", ST_TIMEOUT, rsp2_status);
		end
		$display("test retry finished");
		tcmd(1, ACCESS_KEY, 32'h0000_0055);
		tcmd(0, 8'h11, 32'h0000_0066);
		tcmd(0, ACCESS_KEY, 32'h0000_0077);
		tcmd(0, ACCESS_KEY, 32'h0000_0077);
		$display("test target_faults finished");
		stop_test();
	end
endmodule // tb_top
